/* File: verilog/ftws_defs.vh */
// constants for the two-wire memory slave port
// assumes inclusion by every design file of the port
`ifndef FTWS_DEFS_VH
`define FTWS_DEFS_VH
`define FTWS_TYPE_CODE 4'ha
`define FTWS_HS_CODE 5'h01
`define FTWS_ADDR_W 16
`define FTWS_ADDR_ZERO 16'h0000
`define FTWS_ADDR_ONE 16'h0001
`define FTWS_BYTE_ZERO 8'h00
`define FTWS_BIT_LAST 3'h7
`define FTWS_BIT_ZERO 3'h0
`define FTWS_BIT_ONE 3'h1
`define FTWS_FILT_LEN 3
`endif

/* File: verilog/ftws_pin_sync.v */
// two-flop synchroniser plus majority-free glitch filter for one pin
// assumes an asynchronous pin and a free-running core clock
`timescale 1ns/10ps
`include "ftws_defs.vh"
module ftws_pin_sync #(
  parameter FILT = `FTWS_FILT_LEN
)
(
  input wire core_clk,
  input wire rst,
  input wire clk_en,
  input wire pin_in,
  output wire pin_clean
);
  reg meta_ff; // first stage, read only by sync_ff
  reg sync_ff; // second stage
  reg [FILT-1:0] hist_ff; // recent synced samples
  reg clean_ff; // filtered level
  reg nxt_clean;

  // filtered level moves only when history agrees
  always @*
  begin
    nxt_clean = clean_ff;
    if (&hist_ff)
      nxt_clean = 1'b1;
    else if (~|hist_ff)
      nxt_clean = 1'b0;
  end

  // synchroniser and history; idle bus level is high
  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      meta_ff <= 1'b1;
      sync_ff <= 1'b1;
      hist_ff <= {FILT{1'b1}};
      clean_ff <= 1'b1;
    end
    else if (clk_en)
    begin
      meta_ff <= pin_in;
      sync_ff <= meta_ff;
      hist_ff <= {hist_ff[FILT-2:0], sync_ff};
      clean_ff <= nxt_clean;
    end
  end
  assign pin_clean = clean_ff;
endmodule

/* File: verilog/ftws_mem.v */
// 64k x 8 storage with registered read data
// assumes one write or read per cycle, same clock as the port
`timescale 1ns/10ps
`include "ftws_defs.vh"
module ftws_mem #(
  parameter AW = `FTWS_ADDR_W
)
(
  input wire core_clk,
  input wire clk_en,
  input wire wr_en,
  input wire [AW-1:0] addr,
  input wire [7:0] wr_data,
  output wire [7:0] rd_data
);
  reg [7:0] store [0:(1<<AW)-1]; // array contents
  reg [7:0] rd_ff; // registered read word

  // read before write: registered read returns the old word on a write
  always @(posedge core_clk)
  begin
    if (clk_en)
    begin
      if (wr_en)
        store[addr] <= wr_data;
      rd_ff <= store[addr];
    end
  end
  assign rd_data = rd_ff;
endmodule

/* File: verilog/ftws_slave.v */
// two-wire slave port of a 64k x 8 nonvolatile memory
// assumes scl and sda arrive asynchronously; sda pin is open drain
`timescale 1ns/10ps
`include "ftws_defs.vh"
////////////////////////////////////////////////////////////////////////
module ftws_slave #(
  parameter AW = `FTWS_ADDR_W
)
(
  input wire core_clk,
  input wire rst,
  input wire clk_en,
  input wire scl_in,
  input wire sda_in,
  output wire sda_out,
  output wire sda_oe,
  input wire [2:0] device_select_pins,
  input wire write_protect,
  output wire hs_mode,
  output wire busy
);
  // phase states, one-hot
  localparam [6:0] S_IDLE = 7'h01; // waiting for start
  localparam [6:0] S_ADDR = 7'h02; // taking slave address
  localparam [6:0] S_AHI = 7'h04; // taking memory address high
  localparam [6:0] S_ALO = 7'h08; // taking memory address low
  localparam [6:0] S_WDAT = 7'h10; // taking write data
  localparam [6:0] S_RDAT = 7'h20; // sending read data
  localparam [6:0] S_HS = 7'h40; // master code seen, wait restart

  ////////////////////////////////////////////////////////////////////////
  // pin conditioning
  wire scl_c; // clean scl
  wire sda_c; // clean sda
  reg wp_meta_ff; // write protect first stage
  reg wp_ff; // write protect second stage
  reg [2:0] sel_meta_ff; // select first stage
  reg [2:0] sel_ff; // select second stage

  ftws_pin_sync u_scl_sync (
    .core_clk(core_clk),
    .rst(rst),
    .clk_en(clk_en),
    .pin_in(scl_in),
    .pin_clean(scl_c)
  );
  ftws_pin_sync u_sda_sync (
    .core_clk(core_clk),
    .rst(rst),
    .clk_en(clk_en),
    .pin_in(sda_in),
    .pin_clean(sda_c)
  );

  // static pins get plain two-flop synchronisers
  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      wp_meta_ff <= 1'b0;
      wp_ff <= 1'b0;
      sel_meta_ff <= 3'h0;
      sel_ff <= 3'h0;
    end
    else if (clk_en)
    begin
      wp_meta_ff <= write_protect;
      wp_ff <= wp_meta_ff;
      sel_meta_ff <= device_select_pins;
      sel_ff <= sel_meta_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // edge and condition detection
  reg scl_d_ff; // scl one cycle ago
  reg sda_d_ff; // sda one cycle ago
  wire scl_rise = scl_c & ~scl_d_ff; // capture point
  wire scl_fall = ~scl_c & scl_d_ff; // shift point
  wire start_det = scl_c & scl_d_ff & sda_d_ff & ~sda_c;
  wire stop_det = scl_c & scl_d_ff & ~sda_d_ff & sda_c;

  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      scl_d_ff <= 1'b1;
      sda_d_ff <= 1'b1;
    end
    else if (clk_en)
    begin
      scl_d_ff <= scl_c;
      sda_d_ff <= sda_c;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // decoding helpers
  // slave address match on type code and select pins
  function addr_match;
    input [7:0] b;
    input [2:0] sel;
    begin
      addr_match = (b[7:4] == `FTWS_TYPE_CODE) &
        (b[3:1] == sel);
    end
  endfunction

  // next latch value with wrap
  function [AW-1:0] addr_inc;
    input [AW-1:0] a;
    begin
      addr_inc = a + `FTWS_ADDR_ONE;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // byte engine state
  reg [6:0] state_ff; // protocol phase
  reg [2:0] bit_ff; // bits taken in this byte
  reg ack_ff; // in ninth (ack) slot
  reg [7:0] shift_ff; // incoming byte
  reg [7:0] tx_ff; // outgoing byte
  reg drive_low_ff; // pulls sda low
  reg ack_ok_ff; // this byte is acknowledged by us
  reg hs_ff; // high speed mode
  reg [AW-1:0] addr_ff; // current address latch
  reg [7:0] ahi_ff; // high address byte held
  reg wr_ff; // memory write strobe
  reg [7:0] wdat_ff; // data word for memory
  wire [7:0] mem_rd; // memory read word
  wire [7:0] byte_in = {shift_ff[6:0], sda_c};

  ftws_mem #(
    .AW(AW)
  ) u_mem (
    .core_clk(core_clk),
    .clk_en(clk_en),
    .wr_en(wr_ff),
    .addr(addr_ff),
    .wr_data(wdat_ff),
    .rd_data(mem_rd)
  );

  // main protocol process
  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      state_ff <= S_IDLE;
      bit_ff <= `FTWS_BIT_ZERO;
      ack_ff <= 1'b0;
      shift_ff <= `FTWS_BYTE_ZERO;
      tx_ff <= `FTWS_BYTE_ZERO;
      drive_low_ff <= 1'b0;
      ack_ok_ff <= 1'b0;
      hs_ff <= 1'b0;
      addr_ff <= `FTWS_ADDR_ZERO;
      ahi_ff <= `FTWS_BYTE_ZERO;
      wr_ff <= 1'b0;
      wdat_ff <= `FTWS_BYTE_ZERO;
    end
    else if (clk_en)
    begin
      wr_ff <= 1'b0;
      if (stop_det)
      begin
        // stop aborts everything, drops high speed
        state_ff <= S_IDLE;
        hs_ff <= 1'b0;
        drive_low_ff <= 1'b0;
        ack_ff <= 1'b0;
        bit_ff <= `FTWS_BIT_ZERO;
      end
      else if (start_det)
      begin
        // start aborts and waits for a slave address
        state_ff <= S_ADDR;
        drive_low_ff <= 1'b0;
        ack_ff <= 1'b0;
        bit_ff <= `FTWS_BIT_ZERO;
      end
      else if (state_ff == S_IDLE || state_ff == S_HS)
      begin
        drive_low_ff <= 1'b0; // no activity until start
      end
      else if (scl_rise & ~ack_ff)
      begin
        // capture a data bit on rising scl
        shift_ff <= byte_in;
        bit_ff <= bit_ff + `FTWS_BIT_ONE;
        if (bit_ff == `FTWS_BIT_LAST)
        begin
          // read phase opens its ack slot on the next fall instead
          ack_ff <= (state_ff != S_RDAT);
          ack_ok_ff <= 1'b0;
          case (state_ff)
            S_ADDR:
            begin
              if (byte_in[7:3] == `FTWS_HS_CODE)
                hs_ff <= 1'b1;
              else
                ack_ok_ff <= addr_match(byte_in, sel_ff);
            end
            S_AHI:
            begin
              ahi_ff <= byte_in;
              ack_ok_ff <= 1'b1;
            end
            S_ALO:
            begin
              addr_ff <= {ahi_ff, byte_in};
              ack_ok_ff <= 1'b1;
            end
            S_WDAT:
            begin
              if (~wp_ff)
              begin
                // write, then advance before ack
                wr_ff <= 1'b1;
                wdat_ff <= byte_in;
                ack_ok_ff <= 1'b1;
              end
            end
            S_RDAT:
            begin
              addr_ff <= addr_inc(addr_ff);
            end
            default:
            begin
              ack_ok_ff <= 1'b0;
            end
          endcase
        end
      end
      else if (wr_ff)
      begin
        // advance after the write strobe used the old address
        addr_ff <= addr_inc(addr_ff);
      end
      else if (scl_rise & ack_ff)
      begin
        // sample master ack in read phase
        if (state_ff == S_RDAT && sda_c)
          state_ff <= S_IDLE;
      end
      else if (scl_fall)
      begin
        if (ack_ff & (bit_ff == `FTWS_BIT_ZERO) & ~drive_low_ff &
          ~(state_ff == S_RDAT))
        begin
          // falling edge after eighth bit: enter ack slot
          drive_low_ff <= ack_ok_ff;
          if (~ack_ok_ff)
          begin
            state_ff <= (hs_ff & (state_ff == S_ADDR)) ? S_HS :
              S_IDLE;
            ack_ff <= 1'b0;
          end
          else
            ack_ff <= 1'b1;
        end
        else if (ack_ff)
        begin
          // end of ack slot: move to next phase
          ack_ff <= 1'b0;
          drive_low_ff <= 1'b0;
          case (state_ff)
            S_ADDR:
            begin
              if (shift_ff[0])
              begin
                state_ff <= S_RDAT;
                drive_low_ff <= ~mem_rd[7];
                tx_ff <= {mem_rd[6:0], 1'b0};
              end
              else
                state_ff <= S_AHI;
            end
            S_AHI: state_ff <= S_ALO;
            S_ALO: state_ff <= S_WDAT;
            S_RDAT:
            begin
              // acked: next byte from new address
              drive_low_ff <= ~mem_rd[7];
              tx_ff <= {mem_rd[6:0], 1'b0};
            end
            default: state_ff <= state_ff; // write data stays
          endcase
        end
        else if (state_ff == S_RDAT)
        begin
          // shift next read bit out on falling scl
          if (bit_ff == `FTWS_BIT_ZERO)
          begin
            drive_low_ff <= 1'b0; // release for master ack
            ack_ff <= 1'b1;
          end
          else
          begin
            drive_low_ff <= ~tx_ff[7];
            tx_ff <= {tx_ff[6:0], 1'b0};
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs
  assign sda_out = 1'b0; // open drain: only ever pulls low
  assign sda_oe = drive_low_ff;
  assign hs_mode = hs_ff;
  assign busy = ~(state_ff == S_IDLE);
endmodule

/* File: verif/ftws_slave_checker.sv */
// concurrent checks on the two-wire slave port pins
// assumes pins change off the core clock edge, reset active high
`timescale 1ns/10ps
module ftws_slave_checker #(
  parameter AW = 16
)
(
  input wire core_clk,
  input wire rst,
  input wire clk_en,
  input wire scl_in,
  input wire sda_in,
  input wire sda_out,
  input wire sda_oe,
  input wire [2:0] device_select_pins,
  input wire write_protect,
  input wire hs_mode,
  input wire busy
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////////
  // open drain: the data pin is only ever pulled low
  a_drain_only: assert property (sda_out == 1'b0)
    else $error("sda_out driven high");
  // the device moves sda only while the bus clock is low
  a_oe_scl_low: assert property ($changed(sda_oe) |-> !scl_in)
    else $error("sda_oe changed while scl high");
  // a pulled bit stands for a whole bus clock phase
  a_oe_holds: assert property ($rose(sda_oe) |-> sda_oe [*8])
    else $error("sda_oe pulse too short");
  // idle device never drives the bus
  a_idle_quiet: assert property (!busy && !$past(busy) |-> !sda_oe)
    else $error("sda_oe high while idle");
  // start wakes the port to await an address
  a_start_busy: assert property (scl_in && $past(scl_in)
    && $fell(sda_in) |-> ##[1:12] busy)
    else $error("start not seen");
  // stop drops any operation
  a_stop_idle: assert property (scl_in && $past(scl_in)
    && $rose(sda_in) |-> ##[1:12] !busy)
    else $error("stop did not abort");
  // stop leaves high speed mode
  a_stop_hs: assert property (scl_in && $past(scl_in)
    && $rose(sda_in) |-> ##[1:12] !hs_mode)
    else $error("stop left hs mode on");
  // master code is never acknowledged
  a_hs_no_ack: assert property ($rose(hs_mode) |-> ##1 !sda_oe [*8])
    else $error("master code acknowledged");
endmodule
bind ftws_slave ftws_slave_checker #(.AW(AW)) u_chk (
  .core_clk(core_clk),
  .rst(rst),
  .clk_en(clk_en),
  .scl_in(scl_in),
  .sda_in(sda_in),
  .sda_out(sda_out),
  .sda_oe(sda_oe),
  .device_select_pins(device_select_pins),
  .write_protect(write_protect),
  .hs_mode(hs_mode),
  .busy(busy)
);

/* File: verif/ftws_bus_master.sv */
// bit-level two-wire bus master model
// assumes an open-drain data line pulled up in the bench
`timescale 1ns/10ps
module ftws_bus_master #(
  parameter Q = 4 // core cycles a quarter bit: 80 ns bus clock
)
(
  input wire core_clk,
  input wire sda,
  output logic scl,
  output logic sda_low
);
  // idle: clock parked high, data released
  initial
  begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // wait n quarter bits, then step off the edge
  task qw(input int n);
    repeat (n * Q) @(posedge core_clk);
    #1;
  endtask
  // one pulse: data set in low phase, sampled mid-high
  task bit_io(input logic bo, output logic bi);
    sda_low = !bo;
    qw(1);
    scl = 1'b1;
    qw(1);
    bi = sda;
    qw(1);
    scl = 1'b0;
    qw(1);
  endtask
  task start;
    sda_low = 1'b0;
    qw(1);
    scl = 1'b1;
    qw(1);
    sda_low = 1'b1;
    qw(1);
    scl = 1'b0;
    qw(1);
  endtask
  task stop;
    sda_low = 1'b1;
    qw(1);
    scl = 1'b1;
    qw(1);
    sda_low = 1'b0;
    qw(2);
  endtask
  // byte out, then release for the ack slot
  task wbyte(input logic [7:0] b, output logic ack);
    logic x;
    for (int i = 7; i >= 0; i--) bit_io(b[i], x);
    bit_io(1'b1, x);
    ack = !x;
  endtask
  // byte in; ack slot pulled low only when ack is set
  task rbyte(input logic ack, output logic [7:0] b);
    logic x;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, b[i]);
    bit_io(!ack, x);
  endtask
endmodule

/* File: verif/tb_top.sv */
// self-checking bench for the two-wire memory slave port
// assumes the master model owns scl and pulls sda low
`timescale 1ns/10ps
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin \
  errors++; $display("ERROR %s exp %h got %h", n, e, g); end end
module tb_top;
  logic core_clk, rst, write_protect, sda_oe, sda_out, hs_mode, busy;
  logic [2:0] sel; // select pin levels
  wire scl, m_low, sda;
  int errors, check_count, seed;
  logic ack;
  logic [7:0] rd;
  logic [15:0] a, cur; // cur: bench copy of address latch
  logic [7:0] mem [int]; // bench copy of written bytes
  assign sda = !(m_low | sda_oe); // pull-up, open drain
  ftws_slave DUT (.core_clk(core_clk), .rst(rst), .clk_en(1'b1),
    .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
    .device_select_pins(sel), .write_protect(write_protect),
    .hs_mode(hs_mode), .busy(busy));
  ftws_bus_master m (.core_clk(core_clk), .sda(sda), .scl(scl),
    .sda_low(m_low));
  initial
  begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  ////////////////////////////////////////////////////////////////////////
  function logic [7:0] sa(input logic [3:0] t, input logic [2:0] s,
    input logic r);
    return {t, s, r};
  endfunction
  task test_done;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // bounded wait for the port to go idle
  task idle;
    for (int k = 0; k < 40 && busy !== 1'b0; k++)
    begin
      @(posedge core_clk);
      #1;
    end
    `CHK("busy", 1'b0, busy)
    `CHK("hs_mode", 1'b0, hs_mode)
  endtask
  task probe(input logic [3:0] t, input logic [2:0] s);
    m.start;
    m.wbyte(sa(t, s, 1'b0), ack);
    `CHK("sel ack", t == 4'ha && s == sel, ack)
    m.stop;
    idle;
  endtask
  task set_addr(input logic [15:0] x);
    m.start;
    m.wbyte(sa(4'ha, sel, 1'b0), ack);
    `CHK("wr sel ack", 1'b1, ack)
    m.wbyte(x[15:8], ack);
    `CHK("hi ack", 1'b1, ack)
    m.wbyte(x[7:0], ack);
    `CHK("lo ack", 1'b1, ack)
    cur = x;
  endtask
  // burst write; protected data is refused and latch holds
  task wr(input logic [15:0] x, input int n);
    logic [7:0] d;
    set_addr(x);
    repeat (n)
    begin
      d = $random(seed);
      m.wbyte(d, ack);
      `CHK("data ack", !write_protect, ack)
      if (!write_protect)
      begin
        mem[cur] = d;
        cur = cur + 16'h0001;
      end
    end
    m.stop;
    idle;
  endtask
  // current address read, last byte not acked
  task rd_n(input int n);
    m.start;
    m.wbyte(sa(4'ha, sel, 1'b1), ack);
    `CHK("rd sel ack", 1'b1, ack)
    for (int i = 1; i <= n; i++)
    begin
      m.rbyte(i < n, rd);
      `CHK("rd data", mem[cur], rd)
      cur = cur + 16'h0001;
    end
    m.stop;
    idle;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    seed = 32'hfd57;
    errors = 0;
    check_count = 0;
    rst = 1'b1;
    write_protect = 1'b0;
    sel = $random(seed);
    repeat (3) @(posedge core_clk);
    #1 rst = 1'b0;
    repeat (8) @(posedge core_clk);
    #1;
    wr(16'hfffe, 3);
    set_addr(16'hfffe);
    rd_n(3);
    a = $random(seed);
    wr(a, 4);
    set_addr(a);
    rd_n(2);
    rd_n(2);
    for (int t = 1; t < 16; t++) probe(t[3:0], sel);
    for (int s = 0; s < 8; s++) probe(4'ha, s[2:0]);
    write_protect = 1'b1;
    wr(a, 1);
    write_protect = 1'b0;
    rd_n(1);
    m.start;
    rd = $random(seed);
    m.wbyte({5'b00001, rd[2:0]}, ack);
    `CHK("code ack", 1'b0, ack)
    `CHK("hs on", 1'b1, hs_mode)
    set_addr(a);
    rd_n(1);
    m.start;
    m.wbyte(sa(4'ha, sel, 1'b0), ack);
    repeat (4) m.bit_io(1'b0, ack);
    m.stop;
    idle;
    rd_n(1);
    test_done;
  end
  // hang guard
  initial
  begin
    repeat (90000) @(posedge core_clk);
    errors++;
    test_done;
  end
endmodule
